// file: include/isf_pkg.sv
package isf_pkg;
	// ----------------------------------------------------------------
	// register map (word aligned byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_CONTROL   = 4'h0;
	localparam logic [3:0] ADDR_SLAVE     = 4'h4;
	localparam logic [3:0] ADDR_STATUS    = 4'h8;
	localparam logic [3:0] ADDR_IRQ_STAT  = 4'hC;
	localparam logic [3:0] ADDR_IRQ_MASK  = 4'h0;
	localparam int         ADDR_W         = 4;
	// bus_control_reg fields
	localparam int BIT_WAIT_RELEASE = 5;
	localparam int BIT_COMM_EXIT    = 6;
	localparam int BIT_UNIT_ENABLE  = 7;
	localparam int BIT_MASTER       = 0;
	localparam int BIT_GEN_START    = 1;
	// bus_status_flags fields
	localparam int BIT_TRC          = 3;
	localparam int BIT_COI          = 0;
	localparam int BIT_ALD          = 4;
	// interrupt status fields
	localparam int IRQ_MATCH = 0;
	localparam int IRQ_START = 1;
	localparam int IRQ_STOP  = 2;
	localparam int IRQ_ALD   = 3;
	localparam int IRQ_W     = 4;
	// reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [6:0] SLAVE_RESET   = 7'h00;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
	// ----------------------------------------------------------------
	// address byte tracker states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ADDR = 4'b0010,
		ST_DATA = 4'b0100,
		ST_HOLD = 4'b1000
	} isf_state_type;
endpackage

// file: verilog/isf_sync.sv
`timescale 1ns/1ps
`default_nettype none
module isf_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk_i,   // block clock
	input  wire logic             rst_n_i, // sync reset
	input  wire logic [WIDTH-1:0] async_i, // pin levels
	output logic      [WIDTH-1:0] sync_o   // synchronised levels
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;

	// only stage2 is read outside; stage1 feeds nothing else
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stage1 <= {WIDTH{1'b1}};
			stage2 <= {WIDTH{1'b1}};
		end else begin
			stage1 <= async_i;
			stage2 <= stage1;
		end
	end
	assign sync_o = stage2;
endmodule
`default_nettype wire

// file: verilog/isf_top.sv
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module isf_top
	import isf_pkg::*;
(
	input  wire logic        CLK_I,         // 10 MHz block clock
	input  wire logic        RST_N_I,       // sync reset, active low
	input  wire logic [3:0]  ADDRESS_I,     // avalon byte address
	input  wire logic        READ_I,        // avalon read
	input  wire logic        WRITE_I,       // avalon write
	input  wire logic [31:0] WRITEDATA_I,   // avalon write data
	output logic      [31:0] READDATA_O,    // avalon read data
	output logic             WAITREQUEST_O, // avalon wait
	input  wire logic        SCL_I,         // clock line level
	input  wire logic        SDA_I,         // data line level
	output logic             SDA_O,         // data line drive value
	output logic             SDA_OE_O,      // high while driving data line
	input  wire logic        ALD_I,         // arbitration lost from bus unit
	input  wire logic        LATCH_I,       // serial output latch bit
	output logic             IRQ_O          // level interrupt
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] pins;
	isf_sync #(.WIDTH(2)) u_sync (
		.clk_i   (CLK_I),
		.rst_n_i (RST_N_I),
		.async_i ({SCL_I, SDA_I}),
		.sync_o  (pins)
	);
	logic scl;
	logic sda;
	logic scl_d;
	logic sda_d;
	logic ald_d;
	assign scl = pins[1];
	assign sda = pins[0];

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			ald_d <= 1'b0;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
			ald_d <= ALD_I;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic ald_rise;
	assign scl_rise  = scl & ~scl_d;
	assign scl_fall  = ~scl & scl_d;
	assign start_det = scl & scl_d & sda_d & ~sda;
	assign stop_det  = scl & scl_d & ~sda_d & sda;
	assign ald_rise  = ALD_I & ~ald_d;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0]       control;
	logic [6:0]       slave_addr;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;
	logic [7:0]       next_control;
	logic [6:0]       next_slave_addr;
	logic [IRQ_W-1:0] next_irq_stat;
	logic [IRQ_W-1:0] next_irq_mask;
	logic             wr_ctrl;
	logic             exit_req;
	logic             release_req;
	logic             enable_fall;
	logic             gen_start;

	assign WAITREQUEST_O = 1'b0;
	assign wr_ctrl       = WRITE_I && (ADDRESS_I == ADDR_CONTROL);
	// exit and release act as one-shot strobes; they do not stay set
	assign exit_req      = wr_ctrl && WRITEDATA_I[BIT_COMM_EXIT];
	assign release_req   = wr_ctrl && WRITEDATA_I[BIT_WAIT_RELEASE];
	// a start request only counts when the same write also sets master and keeps the unit enabled
	assign gen_start     = wr_ctrl && WRITEDATA_I[BIT_GEN_START]
	                       && WRITEDATA_I[BIT_MASTER] && WRITEDATA_I[BIT_UNIT_ENABLE];
	assign enable_fall   = control[BIT_UNIT_ENABLE] && wr_ctrl
	                       && !WRITEDATA_I[BIT_UNIT_ENABLE];

	// ----------------------------------------------------------------
	// address byte tracker
	// ----------------------------------------------------------------
	isf_state_type state;
	isf_state_type next_state;
	logic [3:0]    bit_cnt;
	logic [3:0]    next_bit_cnt;
	logic [7:0]    shift;
	logic [7:0]    next_shift;
	logic          coi;
	logic          next_coi;
	logic          trc;
	logic          next_trc;
	logic          master;
	logic          ninth;
	logic          match_now;
	logic          dir_now;

	assign master    = control[BIT_MASTER];
	// bit_cnt counts rises, so it reads nine from the ninth rise to its fall
	assign ninth     = (bit_cnt == 4'h9);
	assign match_now = (state == ST_ADDR) && scl_rise && (bit_cnt == 4'h7)
	                   && (shift[6:0] == slave_addr);
	assign dir_now   = sda;

	always_comb begin
		next_state   = state;
		next_bit_cnt = bit_cnt;
		next_shift   = shift;
		case (state)
			ST_IDLE: begin
				next_bit_cnt = 4'h0;
			end
			ST_ADDR: begin
				// rises are counted so the fall that ends a start is not a bit
				if (scl_rise) begin
					if (bit_cnt < 4'h8) begin
						next_shift = {shift[6:0], sda};
					end
					next_bit_cnt = bit_cnt + 4'h1;
				end
				if (scl_fall && ninth) begin
					next_state   = ST_DATA;
					next_bit_cnt = 4'h0;
				end
			end
			ST_DATA: begin
				if (scl_rise) begin
					next_bit_cnt = bit_cnt + 4'h1;
				end
				if (scl_fall && ninth) begin
					next_bit_cnt = 4'h0;
				end
			end
			ST_HOLD: begin
				next_bit_cnt = 4'h0;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		if (start_det || gen_start) begin
			next_state   = ST_ADDR;
			next_bit_cnt = 4'h0;
		end
		// the enabling write itself may start a frame; control is still old then
		if (stop_det || exit_req || (!control[BIT_UNIT_ENABLE] && !gen_start)) begin
			next_state = ST_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// flag logic; sets follow clears so they win, but the eighth-rise direction sample, set or clear, decides trc last
	// ----------------------------------------------------------------
	always_comb begin
		next_coi = coi;
		if (start_det || stop_det || exit_req || enable_fall) begin
			next_coi = 1'b0;
		end
		if (match_now) begin
			next_coi = 1'b1;
		end
		next_trc = trc;
		if (stop_det || exit_req || enable_fall || ald_rise) begin
			next_trc = 1'b0;
		end
		if (release_req && trc && ninth) begin
			next_trc = 1'b0;
		end
		if (release_req) begin
			next_trc = 1'b0;
		end
		if (gen_start) begin
			next_trc = 1'b1;
		end
		if ((state == ST_ADDR) && scl_rise && (bit_cnt == 4'h7)) begin
			if (master && !dir_now) begin
				next_trc = 1'b1;
			end else if (!master && dir_now && (shift[6:0] == slave_addr)) begin
				next_trc = 1'b1;
			end else begin
				next_trc = 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			state   <= ST_IDLE;
			bit_cnt <= 4'h0;
			shift   <= 8'h00;
			coi     <= 1'b0;
			trc     <= 1'b0;
		end else begin
			state   <= next_state;
			bit_cnt <= next_bit_cnt;
			shift   <= next_shift;
			coi     <= next_coi;
			trc     <= next_trc;
		end
	end

	// ----------------------------------------------------------------
	// data line drive
	// ----------------------------------------------------------------
	// the address byte itself is driven by the bus unit; this block only
	// enables the latch once the first byte's ninth clock has fallen
	logic sda_en;
	logic next_sda_en;
	always_comb begin
		next_sda_en = sda_en;
		if (!next_trc) begin
			next_sda_en = 1'b0;
		end else if (state == ST_ADDR && ninth && scl_fall) begin
			next_sda_en = 1'b1;
		end
	end
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			sda_en <= 1'b0;
			SDA_O  <= 1'b1;
		end else begin
			sda_en <= next_sda_en;
			SDA_O  <= LATCH_I;
		end
	end
	assign SDA_OE_O = sda_en & trc;

	// ----------------------------------------------------------------
	// software registers and interrupts
	// ----------------------------------------------------------------
	logic [IRQ_W-1:0] irq_evt;
	assign irq_evt = {ald_rise, stop_det, start_det, match_now};

	always_comb begin
		next_control    = control;
		next_slave_addr = slave_addr;
		next_irq_mask   = irq_mask;
		next_irq_stat   = irq_stat;
		if (wr_ctrl) begin
			next_control = {WRITEDATA_I[7], 2'b00, 3'b000, 1'b0, WRITEDATA_I[0]};
		end
		if (WRITE_I && ADDRESS_I == ADDR_SLAVE) begin
			next_slave_addr = WRITEDATA_I[6:0];
		end
		if (WRITE_I && ADDRESS_I == ADDR_IRQ_STAT) begin
			next_irq_stat = irq_stat & ~WRITEDATA_I[IRQ_W-1:0];
		end
		next_irq_stat = next_irq_stat | irq_evt;
		if (WRITE_I && ADDRESS_I == ADDR_STATUS) begin
			next_irq_mask = WRITEDATA_I[IRQ_W+7:8];
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			control    <= CONTROL_RESET;
			slave_addr <= SLAVE_RESET;
			irq_stat   <= IRQ_RESET;
			irq_mask   <= IRQ_RESET;
		end else begin
			control    <= next_control;
			slave_addr <= next_slave_addr;
			irq_stat   <= next_irq_stat;
			irq_mask   <= next_irq_mask;
		end
	end

	assign IRQ_O = |(irq_stat & irq_mask);

	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (ADDRESS_I)
			ADDR_CONTROL: next_rdata = {24'h000000, control};
			ADDR_SLAVE:   next_rdata = {25'h0000000, slave_addr};
			ADDR_STATUS: begin
				next_rdata[BIT_COI] = coi;
				next_rdata[BIT_TRC] = trc;
				next_rdata[BIT_ALD] = ALD_I;
				next_rdata[IRQ_W+7:8] = irq_mask;
			end
			ADDR_IRQ_STAT: next_rdata = {28'h0000000, irq_stat};
			default:       next_rdata = 32'h0000_0000;
		endcase
	end
	// read data combinational from registered state and the raw ALD_I level, zero wait
	assign READDATA_O = READ_I ? next_rdata : 32'h0000_0000;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// eighth rise of the address byte, where match and direction are taken
	sequence addr_eighth_rise;
		(state == ST_ADDR) && scl_rise && (bit_cnt == 4'h7);
	endsequence
	// ninth clock of the first byte falling, where the drive may begin
	sequence first_ninth_fall;
		(state == ST_ADDR) && ninth && scl_fall;
	endsequence
	chk_match_set: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		match_now && !start_det |=> coi) else $error("match flag not set");
	chk_match_clr: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(stop_det || exit_req) && !match_now |=> !coi) else $error("match not cleared");
	chk_float_rx: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		!trc |-> !SDA_OE_O) else $error("driving in receive");
	chk_drive_val: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		$rose(SDA_OE_O) |-> $past(state == ST_ADDR && ninth && scl_fall)
		&& SDA_O == $past(LATCH_I)) else $error("bad drive");
	chk_drive_start: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		first_ninth_fall ##0 next_trc |=> SDA_OE_O) else $error("drive not enabled");
	chk_dir_clr: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(stop_det || ald_rise) && !gen_start |=> !trc || $past(state == ST_ADDR))
		else $error("direction not cleared");
	chk_start_dir: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		gen_start |=> trc) else $error("start did not set direction");
	chk_exit_bits: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		exit_req && !gen_start |=> !trc ##0 state == ST_IDLE)
		else $error("exit ignored");
	chk_stop_idle: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		stop_det |=> state == ST_IDLE) else $error("stop not seen");
	chk_release: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		release_req && !gen_start && !(state == ST_ADDR && bit_cnt == 4'h7)
		|=> !trc [*2]) else $error("release kept direction");
	chk_master_dir: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		addr_eighth_rise ##0 (master && !dir_now) |=> trc) else $error("master write bit lost");
	chk_slave_dir: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		addr_eighth_rise ##0 (!master && dir_now && shift[6:0] == slave_addr)
		|=> trc) else $error("slave read bit lost");
endmodule
`default_nettype wire

// file: test/isf_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module isf_bus_model (
	input  wire logic clk_i,  // block clock, paces the far side
	output logic      scl_o,  // clock line, idles high between frames
	output logic      sdl_o   // high while pulling the data line low
);
	initial begin
		scl_o = 1'b1;
		sdl_o = 1'b0;
	end
	// ----------------------------------------------------------------
	// line steps, half a link period is four block cycles
	// ----------------------------------------------------------------
	task automatic hold4();
		repeat (4) @(posedge clk_i);
	endtask
	task automatic start();
		sdl_o <= 1'b0;
		hold4();
		scl_o <= 1'b1;
		hold4();
		sdl_o <= 1'b1;
		hold4();
		scl_o <= 1'b0;
	endtask
	task automatic bit_out(input logic b);
		sdl_o <= ~b;
		hold4();
		scl_o <= 1'b1;
		hold4();
		scl_o <= 1'b0;
	endtask
	// ninth clock leaves the line released so the slave may answer
	task automatic send(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			bit_out(d[i]);
		end
		bit_out(1'b1);
		hold4();
	endtask
	task automatic stop();
		sdl_o <= 1'b1;
		hold4();
		scl_o <= 1'b1;
		hold4();
		sdl_o <= 1'b0;
		hold4();
	endtask
endmodule
`default_nettype wire

// file: test/i2c_status_flag_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_status_flag_logic_tb;
	import isf_pkg::*;
	typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] e;} isf_row_type;
	logic        CLK_I = 0, RST_N_I = 0, READ_I = 0, WRITE_I = 0, ALD_I = 0, LATCH_I = 0;
	logic [3:0]  ADDRESS_I = 0;
	logic [31:0] WRITEDATA_I = 0, q;
	wire  [31:0] READDATA_O;
	wire         WAITREQUEST_O, SDA_O, SDA_OE_O, IRQ_O, scl, m_low;
	// pull-up: high unless someone pulls the line low
	wire         sda = ~(m_low | (SDA_OE_O & ~SDA_O));
	int          n_errors = 0, cmp_count = 0;
	isf_row_type rows [3] = '{'{ADDR_CONTROL, 32'hE0, 32'h80},
		'{4'h2, 32'hFF, 32'h0}, '{ADDR_STATUS, 32'hF00, 32'hF00}};
	always #50 CLK_I = ~CLK_I;
	isf_top dut (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDRESS_I(ADDRESS_I), .READ_I(READ_I),
		.WRITE_I(WRITE_I), .WRITEDATA_I(WRITEDATA_I), .READDATA_O(READDATA_O),
		.WAITREQUEST_O(WAITREQUEST_O), .SCL_I(scl), .SDA_I(sda), .SDA_O(SDA_O),
		.SDA_OE_O(SDA_OE_O), .ALD_I(ALD_I), .LATCH_I(LATCH_I), .IRQ_O(IRQ_O));
	isf_bus_model bus (.clk_i(CLK_I), .scl_o(scl), .sdl_o(m_low));
	// ----------------------------------------------------------------
	// bus cycles and comparison
	// ----------------------------------------------------------------
	task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
		ADDRESS_I <= a;
		WRITE_I <= w;
		READ_I <= ~w;
		WRITEDATA_I <= d;
		@(posedge CLK_I);
		while (WAITREQUEST_O !== 1'b0) @(posedge CLK_I);
		q = READDATA_O;
		READ_I <= 1'b0;
		WRITE_I <= 1'b0;
		@(posedge CLK_I);
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic flags(input logic [31:0] exp);
		av(ADDR_STATUS, 1'b0, 32'h0);
		chk("status", q & 32'h19, exp);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#2000000;
		n_errors++;
		report_and_stop();
	end
	initial begin
		repeat (3) @(posedge CLK_I);
		RST_N_I <= 1'b1;
		@(posedge CLK_I);
		flags(32'h0);
		av(ADDR_CONTROL, 1'b0, 32'h0);
		chk("control", q, {24'h0, CONTROL_RESET});
		chk("oe", SDA_OE_O, 1'b0);
		$display("reset test done");
		for (int i = 0; i < 3; i++) begin
			av(rows[i].a, 1'b1, rows[i].d);
			av(rows[i].a, 1'b0, 32'h0);
			chk("row", q, rows[i].e);
		end
		$display("register rows done");
		av(ADDR_SLAVE, 1'b1, 32'h2A);
		bus.start();
		bus.send({7'h2A, 1'b1});
		flags(32'h09);
		chk("oe", SDA_OE_O, 1'b1);
		chk("sdo", SDA_O, 1'b0);
		LATCH_I <= 1'b1;
		repeat (2) @(posedge CLK_I);
		chk("sdo", SDA_O, 1'b1);
		chk("irq", IRQ_O, 1'b1);
		av(ADDR_STATUS, 1'b1, 32'h0);
		chk("irq masked", IRQ_O, 1'b0);
		av(ADDR_IRQ_STAT, 1'b1, 32'hF);
		av(ADDR_STATUS, 1'b1, 32'hF00);
		chk("irq cleared", IRQ_O, 1'b0);
		bus.start();
		flags(32'h08);
		bus.stop();
		flags(32'h0);
		chk("oe", SDA_OE_O, 1'b0);
		$display("slave read test done");
		bus.start();
		bus.send({7'h15, 1'b1});
		flags(32'h0);
		bus.stop();
		// each row of clears: release, exit, disable
		for (int k = 0; k < 3; k++) begin
			av(ADDR_CONTROL, 1'b1, 32'h80);
			bus.start();
			bus.send({7'h2A, 1'b1});
			flags(32'h09);
			av(ADDR_CONTROL, 1'b1, (k == 0) ? 32'hA0 : (k == 1) ? 32'hC0 : 32'h0);
			flags((k == 0) ? 32'h01 : 32'h0);
			chk("oe", SDA_OE_O, 1'b0);
			bus.stop();
		end
		$display("clear test done");
		av(ADDR_CONTROL, 1'b1, 32'h83);
		flags(32'h08);
		bus.start();
		bus.send({7'h15, 1'b1});
		flags(32'h0);
		bus.start();
		bus.send({7'h15, 1'b0});
		flags(32'h08);
		av(ADDR_IRQ_STAT, 1'b1, 32'hF);
		ALD_I <= 1'b1;
		repeat (2) @(posedge CLK_I);
		flags(32'h10);
		chk("irq ald", IRQ_O, 1'b1);
		av(ADDR_IRQ_STAT, 1'b0, 32'h0);
		chk("irq stat", q, 32'h8);
		ALD_I <= 1'b0;
		$display("master test done");
		RST_N_I <= 1'b0;
		repeat (3) @(posedge CLK_I);
		RST_N_I <= 1'b1;
		@(posedge CLK_I);
		flags(32'h0);
		chk("irq reset", IRQ_O, 1'b0);
		$display("mid-run reset test done");
		report_and_stop();
	end
endmodule
`default_nettype wire
